// file: hdl/ppsm_top.sv
// Power state sequencer with Wishbone register slave
// Assumes synchronous PCI reset, power good and wake inputs on MCLK
`timescale 1ns/1ps
`default_nettype none
`include "ppsm_map.svh"

// Overview of operation
// [RULE1] Aux sense high advertises cold D3 wakeup
// [RULE2] Wake bits survive reset only with aux
// [RULE3] Aux sense is level, acts at once
// [RULE4] Reset enters hold, floats pins, bounded isolation
// [RULE5] System asserts reset before dropping main power
// [RULE6] Power good loads EEPROM, legacy wake enable
// [RULE7] Hold state like D3, high level off
// [RULE8] No wakeup in hold: low level off
// [RULE9] No frames or idles in hold
// [RULE10] Reset rising edge enters uninit D0
// [RULE11] Uninit entry: wake off, PHY reset, reload
// [RULE12] Memory enable write moves to active
// [RULE13] Active: clocks on, traffic, full power
// [RULE14] Software clears legacy wake, sets filters
// [RULE15] Software quiesces and arms wake before D3
// [RULE16] Level write 11 enters D3, wakes kept
// [RULE17] D3 entry clears memory and I/O enable
// [RULE18] D3 answers config only, no traffic
// [RULE19] Level write 00 in D3 returns uninit
// [RULE20] Force bit may drive wake without enable
// [RULE21] Register set stays when management disabled
// [RULE22] System keeps clock unless reset asserted
// [RULE23] Clock run request when enabled and needed
// [RULE24] Wait 512 clocks before driving bus (code waits the lesser of ISO_CYCLES and 512)
// [RULE25] One-hot state, powers up in hold
module ppsm_top #(
    parameter int unsigned ISO_CYCLES = `PPSM_ISO_CYC
) (
    input  wire logic                MCLK,
    input  wire logic                ARST_N,
    input  wire logic                WB_CYC_I,
    input  wire logic                WB_STB_I,
    input  wire logic                WB_WE_I,
    input  wire logic [7:0]          WB_ADR_I,
    input  wire logic [3:0]          WB_SEL_I,
    input  wire logic [31:0]         WB_DAT_I,
    output logic      [31:0]         WB_DAT_O,
    output logic                     WB_ACK_O,
    input  wire logic                PCI_RST_N,
    input  wire logic                SUPPLY_GOOD_IN,
    input  wire logic                AUX_SENSE,
    input  wire logic                WAKE_EVENT,
    input  wire logic                EE_DONE,
    input  wire ppsm_pkg::ppsm_ee_s  EE_WORD,
    output var  ppsm_pkg::ppsm_out_s PWR_OUT
);
    import ppsm_pkg::*;

    localparam logic [15:0] SYNC_LIM = 16'(`PPSM_SYNC_CYC);
    localparam logic [15:0] ISO_LIM  = 16'(ISO_CYCLES);
    localparam logic [15:0] REL_LIM  = (ISO_LIM < SYNC_LIM) ? ISO_LIM : SYNC_LIM;

    // ------------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------------
    logic        ack;
    logic        next_ack;
    logic [31:0] rdat;
    logic [31:0] next_rdat;
    logic        hit;
    logic        wr;
    logic [31:0] rd_val;

    ppsm_state_e state;
    ppsm_state_e next_state;
    logic        cmd_mem;
    logic        cmd_io;
    logic        apm_en;
    logic        wake_signal_enable;
    logic        pme_flag;
    logic        pme_force;
    logic [7:0]  filt;
    ppsm_ee_s    ee;
    logic        rst_q;
    logic        pg_q;
    logic [15:0] cnt;
    ppsm_out_s   out;

    logic        next_cmd_mem;
    logic        next_cmd_io;
    logic        next_apm_en;
    logic        next_wake_signal_enable;
    logic        next_pme_flag;
    logic        next_pme_force;
    logic [7:0]  next_filt;
    ppsm_ee_s    next_ee;
    logic [15:0] next_cnt;
    ppsm_out_s   next_out;
    logic        wake_any;
    logic        rst_rise;
    logic        isolate;

    assign hit = WB_CYC_I & WB_STB_I & ack;
    assign wr  = hit & WB_WE_I;

    // Full register set even with management disabled [RULE21]
    always_comb begin
        rd_val = 32'h0000_0000;
        case (WB_ADR_I)
            `PPSM_OFS_POWER_MGMT_CTRL_STATUS: begin
                rd_val[`PPSM_PM_LVL_HI:`PPSM_PM_LVL_LO] =
                    (state == D3_STATE) ? `PPSM_LVL_D3 : `PPSM_LVL_D0;
                rd_val[`PPSM_PM_EN_BIT]  = wake_signal_enable;
                rd_val[`PPSM_PM_FLG_BIT] = pme_flag;
            end
            `PPSM_OFS_CMD: begin
                rd_val[`PPSM_CMD_IO_BIT]  = cmd_io;
                rd_val[`PPSM_CMD_MEM_BIT] = cmd_mem;
            end
            `PPSM_OFS_WAKE: begin
                rd_val[`PPSM_WK_APM_BIT] = apm_en;
                rd_val[`PPSM_WK_EN_BIT]  = wake_signal_enable;
                rd_val[`PPSM_WK_FLG_BIT] = pme_flag;
                rd_val[`PPSM_WK_FRC_BIT] = pme_force;
            end
            `PPSM_OFS_FILT: rd_val[7:0] = filt;
            `PPSM_OFS_STAT: begin
                rd_val[3:0] = state;
                rd_val[4]   = AUX_SENSE;
                rd_val[5]   = out.d3cold_adv;
                rd_val[6]   = isolate;
                rd_val[7]   = ~isolate;
                rd_val[8]   = ee.legacy_wake_select;
                rd_val[9]   = ee.pm_disable;
                rd_val[10]  = ee.clkrun_en;
            end
            default: rd_val = 32'h0000_0000;
        endcase
    end

    always_comb begin
        next_ack  = WB_CYC_I & WB_STB_I & ~ack;
        next_rdat = next_ack ? rd_val : 32'h0000_0000;
    end

    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ack  <= 1'b0;
            rdat <= 32'h0000_0000;
        end else begin
            ack  <= next_ack;
            rdat <= next_rdat;
        end
    end

    assign WB_ACK_O = ack;
    assign WB_DAT_O = rdat;

    // ------------------------------------------------------------------
    // Power state sequencer
    // ------------------------------------------------------------------
    assign wake_any = apm_en | wake_signal_enable | (|filt);
    assign rst_rise = PCI_RST_N & ~rst_q;
    assign isolate  = (state == RESET_HOLD_STATE) | (cnt < REL_LIM);

    always_comb begin
        next_state     = state;
        next_cmd_mem   = cmd_mem;
        next_cmd_io    = cmd_io;
        next_apm_en    = apm_en;
        next_wake_signal_enable    = wake_signal_enable;
        next_pme_flag  = pme_flag;
        next_pme_force = pme_force;
        next_filt      = filt;
        next_ee        = ee;
        next_cnt       = (cnt < REL_LIM) ? cnt + 16'h0001 : cnt;
        next_out       = out;
        next_out.ee_load   = 1'b0;
        next_out.phy_reset = 1'b0;
        if (wr && WB_ADR_I == `PPSM_OFS_POWER_MGMT_CTRL_STATUS) begin
            if (WB_SEL_I[1]) begin
                next_wake_signal_enable = WB_DAT_I[`PPSM_PM_EN_BIT];
                if (WB_DAT_I[`PPSM_PM_FLG_BIT])
                    next_pme_flag = 1'b0;
            end
        end
        if (wr && WB_ADR_I == `PPSM_OFS_CMD && WB_SEL_I[0]) begin
            next_cmd_io  = WB_DAT_I[`PPSM_CMD_IO_BIT];
            next_cmd_mem = WB_DAT_I[`PPSM_CMD_MEM_BIT];
        end
        if (wr && WB_ADR_I == `PPSM_OFS_WAKE && WB_SEL_I[0]) begin
            next_apm_en    = WB_DAT_I[`PPSM_WK_APM_BIT];    // [RULE14]
            next_wake_signal_enable    = WB_DAT_I[`PPSM_WK_EN_BIT];
            next_pme_force = WB_DAT_I[`PPSM_WK_FRC_BIT];
            if (WB_DAT_I[`PPSM_WK_FLG_BIT])
                next_pme_flag = 1'b0;
        end
        if (wr && WB_ADR_I == `PPSM_OFS_FILT && WB_SEL_I[0])
            next_filt = WB_DAT_I[7:0];                      // [RULE14]
        if (WAKE_EVENT && wake_any)
            next_pme_flag = 1'b1;
        if (EE_DONE) begin
            next_ee = EE_WORD;
            if (EE_WORD.legacy_wake_select)
                next_apm_en = 1'b1;                         // [RULE6] [RULE11]
        end
        if (SUPPLY_GOOD_IN && !pg_q)
            next_out.ee_load = 1'b1;                        // [RULE6]
        if (!SUPPLY_GOOD_IN) begin
            next_state     = RESET_HOLD_STATE;
            next_cmd_mem   = 1'b0;
            next_cmd_io    = 1'b0;
            next_apm_en    = 1'b0;
            next_wake_signal_enable    = 1'b0;
            next_pme_flag  = 1'b0;
            next_pme_force = 1'b0;
            next_filt      = `PPSM_FILT_RST;
            next_cnt       = 16'h0000;
        end else if (!PCI_RST_N) begin
            next_state   = RESET_HOLD_STATE;                // [RULE4] [RULE7]
            next_cmd_mem = 1'b0;
            next_cmd_io  = 1'b0;
            next_cnt     = 16'h0000;
        end else begin
            case (state)
                RESET_HOLD_STATE: begin
                    if (rst_rise) begin
                        next_state = D0_UNINIT;             // [RULE10]
                        next_cnt   = 16'h0000;              // [RULE24]
                        if (!AUX_SENSE) begin
                            next_wake_signal_enable   = 1'b0;           // [RULE2] [RULE3]
                            next_pme_flag = 1'b0;
                            next_pme_force = 1'b0;
                        end
                        next_apm_en        = 1'b0;          // [RULE11]
                        next_filt          = `PPSM_FILT_RST;
                        next_out.phy_reset = 1'b1;
                        next_out.ee_load   = 1'b1;
                    end
                end
                D0_UNINIT: begin
                    if (wr && WB_ADR_I == `PPSM_OFS_CMD && WB_SEL_I[0]
                        && WB_DAT_I[`PPSM_CMD_MEM_BIT])
                        next_state = D0_ACTIVE;             // [RULE12]
                end
                D0_ACTIVE: begin
                    if (wr && WB_ADR_I == `PPSM_OFS_POWER_MGMT_CTRL_STATUS && WB_SEL_I[0]
                        && WB_DAT_I[`PPSM_PM_LVL_HI:`PPSM_PM_LVL_LO] == `PPSM_LVL_D3) begin
                        next_state   = D3_STATE;            // [RULE16]
                        next_cmd_mem = 1'b0;                // [RULE17]
                        next_cmd_io  = 1'b0;
                    end
                end
                D3_STATE: begin
                    next_cmd_mem = 1'b0;                    // [RULE18]
                    next_cmd_io  = 1'b0;
                    if (wr && WB_ADR_I == `PPSM_OFS_POWER_MGMT_CTRL_STATUS && WB_SEL_I[0]
                        && WB_DAT_I[`PPSM_PM_LVL_HI:`PPSM_PM_LVL_LO] == `PPSM_LVL_D0) begin
                        next_state         = D0_UNINIT;     // [RULE19]
                        next_apm_en        = 1'b0;          // [RULE11]
                        next_filt          = `PPSM_FILT_RST;
                        next_out.phy_reset = 1'b1;
                        next_out.ee_load   = 1'b1;
                    end
                end
                default: next_state = RESET_HOLD_STATE;
            endcase
        end
        next_out.d3cold_adv         = AUX_SENSE;            // [RULE1] [RULE3]
        next_out.power_level_out_hi = (state == D0_ACTIVE); // [RULE7]
        next_out.power_level_out_lo = (state == D0_ACTIVE) | wake_any; // [RULE8]
        next_out.pci_isolate        = isolate;              // [RULE4]
        next_out.pci_ready          = ~isolate;             // [RULE24]
        next_out.mem_decode_en      = cmd_mem & (state == D0_ACTIVE);
        next_out.io_decode_en       = cmd_io & (state == D0_ACTIVE);
        next_out.master_en          = (state == D0_ACTIVE) & ~isolate; // [RULE18]
        next_out.tx_rx_en           = (state == D0_ACTIVE); // [RULE9] [RULE13]
        next_out.clk_gate           = (state != D0_ACTIVE); // [RULE13]
        next_out.phy_full_power     = (state == D0_ACTIVE); // [RULE13]
        next_out.pme_o              = 1'b0;
        next_out.pme_oe_n           = ~(pme_flag & (wake_signal_enable | pme_force)); // [RULE20]
        next_out.clk_run_o          = 1'b0;
        next_out.clk_run_oe_n       = ~(ee.clkrun_en &
            ((state == D0_ACTIVE) | (cnt < REL_LIM) | pme_flag)); // [RULE23]
        next_out.dev_state          = state;
    end

    // Powers up in the hold state [RULE25]
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            state     <= RESET_HOLD_STATE;
            cmd_mem   <= 1'b0;
            cmd_io    <= 1'b0;
            apm_en    <= 1'b0;
            wake_signal_enable    <= 1'b0;
            pme_flag  <= 1'b0;
            pme_force <= 1'b0;
            filt      <= `PPSM_FILT_RST;
            ee        <= '0;
            rst_q     <= 1'b0;
            pg_q      <= 1'b0;
            cnt       <= 16'h0000;
            out       <= '{pme_oe_n: 1'b1, clk_run_oe_n: 1'b1, pci_isolate: 1'b1,
                           clk_gate: 1'b1, dev_state: RESET_HOLD_STATE, default: 1'b0};
        end else begin
            state     <= next_state;
            cmd_mem   <= next_cmd_mem;
            cmd_io    <= next_cmd_io;
            apm_en    <= next_apm_en;
            wake_signal_enable    <= next_wake_signal_enable;
            pme_flag  <= next_pme_flag;
            pme_force <= next_pme_force;
            filt      <= next_filt;
            ee        <= next_ee;
            rst_q     <= PCI_RST_N;
            pg_q      <= SUPPLY_GOOD_IN;
            cnt       <= next_cnt;
            out       <= next_out;
        end
    end

    assign PWR_OUT = out;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!ARST_N);

    sequence s_rise_in_hold;
        SUPPLY_GOOD_IN && state == RESET_HOLD_STATE && rst_rise;
    endsequence

    sequence s_held_up;
        (PCI_RST_N && SUPPLY_GOOD_IN) [*8];
    endsequence

    a_reset_hold: assert property ( // [RULE4]
        !PCI_RST_N |=> state == RESET_HOLD_STATE ##1 PWR_OUT.pci_isolate)
        else $error("reset did not enter hold");
    a_rise_uninit: assert property ( // [RULE10]
        s_rise_in_hold |=> state == D0_UNINIT && PWR_OUT.phy_reset && PWR_OUT.ee_load)
        else $error("reset rise did not reach uninit");
    a_iso_held: assert property ( // [RULE24]
        s_rise_in_hold ##1 s_held_up |-> PWR_OUT.pci_isolate)
        else $error("bus released too early");
    a_wake_cleared: assert property ( // [RULE2]
        s_rise_in_hold and !AUX_SENSE |=> !wake_signal_enable && !pme_flag)
        else $error("wake bits kept without aux");
    a_wake_kept: assert property ( // [RULE2]
        s_rise_in_hold and AUX_SENSE && !wr |=> wake_signal_enable == $past(wake_signal_enable))
        else $error("wake enable lost with aux");
    a_hi_level: assert property ( // [RULE7]
        state != D0_ACTIVE |=> !PWR_OUT.power_level_out_hi)
        else $error("high level on outside active");
    a_lo_level: assert property ( // [RULE8]
        state == RESET_HOLD_STATE && !wake_any |=> !PWR_OUT.power_level_out_lo)
        else $error("low level on without wakeup");
    a_mem_active: assert property ( // [RULE12]
        PCI_RST_N && SUPPLY_GOOD_IN && state == D0_UNINIT && wr
        && WB_ADR_I == `PPSM_OFS_CMD && WB_SEL_I[0] && WB_DAT_I[`PPSM_CMD_MEM_BIT]
        |=> state == D0_ACTIVE)
        else $error("memory enable did not activate");
    a_d3_cmd: assert property ( // [RULE17]
        $rose(state == D3_STATE) |-> !cmd_mem && !cmd_io ##1 !PWR_OUT.master_en)
        else $error("decode left on in D3");
    a_aux_adv: assert property ( // [RULE1]
        ##1 PWR_OUT.d3cold_adv == $past(AUX_SENSE))
        else $error("cold wake advert wrong");
    a_pme_force: assert property ( // [RULE20]
        pme_flag && pme_force |=> !PWR_OUT.pme_oe_n)
        else $error("forced wake not driven");

endmodule
`default_nettype wire

// file: hdl/ppsm_map.svh
// Register offsets, field positions, reset values and timing counts
// Assumes inclusion by the power state manager top module
`ifndef PPSM_MAP_SVH
`define PPSM_MAP_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define PPSM_OFS_POWER_MGMT_CTRL_STATUS   8'h00
`define PPSM_OFS_CMD     8'h04
`define PPSM_OFS_WAKE    8'h08
`define PPSM_OFS_FILT    8'h0C
`define PPSM_OFS_STAT    8'h10

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define PPSM_PM_LVL_LO   0
`define PPSM_PM_LVL_HI   1
`define PPSM_PM_EN_BIT   8
`define PPSM_PM_FLG_BIT  15
`define PPSM_CMD_IO_BIT  0
`define PPSM_CMD_MEM_BIT 1
`define PPSM_WK_APM_BIT  0
`define PPSM_WK_EN_BIT   1
`define PPSM_WK_FLG_BIT  2
`define PPSM_WK_FRC_BIT  3

// ----------------------------------------------------------------------
// Encodings and reset values
// ----------------------------------------------------------------------
`define PPSM_LVL_D0      2'h0
`define PPSM_LVL_D3      2'h3
`define PPSM_FILT_RST    8'h00

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define PPSM_CLK_MHZ     50
`define PPSM_ISO_US      1000
`define PPSM_ISO_CYC     (`PPSM_ISO_US * `PPSM_CLK_MHZ)
`define PPSM_SYNC_CYC    512

`endif

// file: hdl/ppsm_pkg.sv
// Types of the power state manager
// Assumes nothing beyond a SystemVerilog compiler
package ppsm_pkg;

    // ------------------------------------------------------------------
    // Power states
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        RESET_HOLD_STATE = 4'h1,
        D0_UNINIT        = 4'h2,
        D0_ACTIVE        = 4'h4,
        D3_STATE         = 4'h8
    } ppsm_state_e;

    // ------------------------------------------------------------------
    // Configuration word fields from the EEPROM
    // ------------------------------------------------------------------
    typedef struct packed {
        logic legacy_wake_select;
        logic pm_disable;
        logic clkrun_en;
    } ppsm_ee_s;

    // ------------------------------------------------------------------
    // Control outputs
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       ee_load;
        logic       phy_reset;
        logic       power_level_out_hi;
        logic       power_level_out_lo;
        logic       d3cold_adv;
        logic       pci_isolate;
        logic       pci_ready;
        logic       mem_decode_en;
        logic       io_decode_en;
        logic       master_en;
        logic       tx_rx_en;
        logic       clk_gate;
        logic       phy_full_power;
        logic       pme_o;
        logic       pme_oe_n;
        logic       clk_run_o;
        logic       clk_run_oe_n;
        logic [3:0] dev_state;
    } ppsm_out_s;

endpackage

// file: tb/ppsm_host_model.sv
// Host side model: PCI reset, power good and EEPROM responder
// Assumes the power state manager package is compiled first
`timescale 1ns/1ps
`default_nettype none
module ppsm_host_model (
    input  wire logic               clk,
    input  wire logic               arst_n,
    input  wire logic               ee_load,
    input  wire ppsm_pkg::ppsm_ee_s cfg,
    input  wire logic               slow,
    input  wire logic               power_on,
    input  wire logic               rst_req,
    output logic                    pci_rst_n,
    output logic                    supply_good,
    output logic                    ee_done,
    output var ppsm_pkg::ppsm_ee_s  ee_word
);
    import ppsm_pkg::*;
    logic [4:0] wait_cnt;
    logic       busy;
    // ------------------------------------------------------------
    // Reset sequencing and EEPROM answer
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pci_rst_n <= 1'b0;
            supply_good <= 1'b0;
            ee_done <= 1'b0;
            busy <= 1'b0;
            wait_cnt <= 5'h0;
            ee_word <= '0;
        end else begin
            pci_rst_n <= power_on & ~rst_req;
            supply_good <= power_on | pci_rst_n;
            ee_done <= 1'b0;
            ee_word <= ~ee_word;
            if (ee_load) begin
                busy <= 1'b1;
                wait_cnt <= slow ? 5'h14 : 5'h2;
            end else if (busy && wait_cnt == 5'h0) begin
                busy <= 1'b0;
                ee_done <= 1'b1;
                ee_word <= cfg;
            end else if (busy) begin
                wait_cnt <= wait_cnt - 5'h1;
            end
        end
    end
endmodule
`default_nettype wire

// file: tb/ppsm_top_tb.sv
// Self-checking bench for the power state manager
// Assumes the design files and the host model are compiled first
`timescale 1ns/1ps
`default_nettype none
module ppsm_top_tb;
    import ppsm_pkg::*;
    localparam int ISO = 64;
    typedef struct {logic [31:0] m; logic [31:0] v; string n;} ppsm_note_s;
    logic mclk = 1'b0, arst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic aux = 1'b0, wake = 1'b0, power_on = 1'b0, rst_req = 1'b1, slow = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat = 32'h0, rdat, r;
    logic ack, prst_n, sgood, ee_done;
    ppsm_ee_s ee_word, ee_cfg = '0;
    ppsm_out_s pwr;
    ppsm_note_s exp_q[$], note;
    int fail_count = 0, tests_run = 0, n_ee = 0, n_phy = 0, k;
    // ------------------------------------------------------------
    // Clock, design and host
    // ------------------------------------------------------------
    initial begin
        forever #10 mclk = ~mclk;
    end
    ppsm_top #(.ISO_CYCLES(ISO)) u_ppsm_top (
        .MCLK(mclk), .ARST_N(arst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
        .PCI_RST_N(prst_n), .SUPPLY_GOOD_IN(sgood), .AUX_SENSE(aux), .WAKE_EVENT(wake),
        .EE_DONE(ee_done), .EE_WORD(ee_word), .PWR_OUT(pwr));
    ppsm_host_model u_ppsm_host_model (
        .clk(mclk), .arst_n(arst_n), .ee_load(pwr.ee_load), .cfg(ee_cfg), .slow(slow),
        .power_on(power_on), .rst_req(rst_req), .pci_rst_n(prst_n), .supply_good(sgood),
        .ee_done(ee_done), .ee_word(ee_word));
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic final_report;
        if (fail_count == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic abort;
        fail_count++;
        final_report();
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge mclk);
        @(negedge mclk);
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [31:0] m, input string n);
        int t;
        t = 0;
        @(posedge mclk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'hF;
        dat <= w ? d : 32'h0;
        if (!w) exp_q.push_back('{m, d & m, n});
        do begin
            @(posedge mclk);
            t++;
        end while (ack !== 1'b1 && t < 50);
        if (t >= 50) abort();
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb(1'b1, a, d, 32'h0, "");
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                      input string n);
        wb(1'b0, a, e, m, n);
    endtask
    task automatic pci_reset(input logic hold);
        @(posedge mclk);
        rst_req <= hold;
        idle(4);
    endtask
    // ------------------------------------------------------------
    // Read monitor and pulse counters
    // ------------------------------------------------------------
    always @(posedge mclk) begin
        if (ack === 1'b1 && we === 1'b0 && cyc === 1'b1) begin
            if (exp_q.size() == 0) begin
                chk("spare read", 32'h0, 32'h1);
            end else begin
                note = exp_q.pop_front();
                chk(note.n, note.v, rdat & note.m);
            end
        end
        if (pwr.ee_load === 1'b1) n_ee++;
        if (pwr.phy_reset === 1'b1) n_phy++;
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(16496));
        repeat (16) @(posedge mclk);
        arst_n <= 1'b1;
        idle(2);
        chk("state", 32'h1, pwr.dev_state);
        chk("isolate", 32'h1, pwr.pci_isolate);
        chk("levels", 32'h0, {pwr.power_level_out_hi, pwr.power_level_out_lo});
        chk("traffic", 32'h0, pwr.tx_rx_en);
        @(posedge mclk);
        ee_cfg <= ppsm_ee_s'(3'h5);
        power_on <= 1'b1;
        idle(40);
        chk("boot load", 32'h1, n_ee > 0);
        n_ee = 0;
        @(posedge mclk);
        rst_req <= 1'b0;
        for (k = 0; k < 600 && pwr.pci_isolate !== 1'b0; k++) @(posedge mclk);
        if (k == 600) abort();
        chk("isolation span", 32'h1, k >= ISO && k <= ISO + 6);
        chk("ready", 32'h1, pwr.pci_ready);
        chk("reload", 32'h3, {n_phy > 0, n_ee > 0});
        rd(8'h10, 32'hF, 32'h2, "state");
        rd(8'h08, 32'h1, 32'h1, "legacy wake");
        wr(8'h04, 32'h2);
        idle(3);
        chk("active", 32'h7F, {pwr.power_level_out_hi, pwr.tx_rx_en, pwr.phy_full_power,
            ~pwr.clk_gate, pwr.mem_decode_en, ~pwr.clk_run_oe_n, pwr.master_en});
        rd(8'h08, 32'h1, 32'h1, "legacy kept");
        wr(8'h08, 32'h0);
        rd(8'h08, 32'h1, 32'h0, "legacy off");
        for (int i = 0; i < 4; i++) begin
            r = $urandom() & 32'hFF;
            wr(8'h0C, r);
            rd(8'h0C, 32'hFF, r, "filters");
        end
        rd(8'h14, 32'hFFFFFFFF, 32'h0, "unmapped");
        wr(8'h08, 32'h8);
        rd(8'h08, 32'h8, 32'h8, "force bit");
        wr(8'h00, 32'h101);
        rd(8'h00, 32'h103, 32'h100, "odd level");
        wr(8'h00, 32'h103);
        idle(3);
        rd(8'h00, 32'h103, 32'h103, "d3 level");
        rd(8'h04, 32'h3, 32'h0, "cmd in d3");
        chk("d3 outs", 32'h1, {pwr.master_en, pwr.tx_rx_en, pwr.mem_decode_en,
            pwr.io_decode_en, pwr.power_level_out_lo});
        @(posedge mclk);
        wake <= 1'b1;
        @(posedge mclk);
        wake <= 1'b0;
        rd(8'h00, 32'h8000, 32'h8000, "wake flag");
        chk("wake pin", 32'h0, {pwr.pme_o, pwr.pme_oe_n, pwr.clk_run_o});
        wr(8'h00, 32'h100);
        idle(2);
        rd(8'h10, 32'hF, 32'h2, "state");
        @(posedge mclk);
        aux <= 1'b1;
        idle(2);
        chk("cold adv", 32'h1, pwr.d3cold_adv);
        pci_reset(1'b1);
        chk("hold", 32'h3, {pwr.dev_state, pwr.pci_isolate});
        chk("hold levels", 32'h1, {pwr.power_level_out_hi, pwr.power_level_out_lo});
        pci_reset(1'b0);
        rd(8'h00, 32'h8100, 32'h8100, "kept wake");
        @(posedge mclk);
        aux <= 1'b0;
        ee_cfg <= ppsm_ee_s'(3'h2);
        slow <= 1'b1;
        idle(2);
        chk("cold adv", 32'h0, pwr.d3cold_adv);
        pci_reset(1'b1);
        pci_reset(1'b0);
        idle(30);
        rd(8'h00, 32'h8100, 32'h0, "cleared wake");
        wr(8'h0C, 32'h5A);
        rd(8'h0C, 32'hFF, 32'h5A, "pm off regs");
        wr(8'h0C, 32'h0);
        pci_reset(1'b1);
        chk("idle levels", 32'h0, {pwr.power_level_out_hi, pwr.power_level_out_lo});
        chk("hold traffic", 32'h0, {pwr.tx_rx_en, pwr.master_en});
        final_report();
    end
endmodule
`default_nettype wire
